// >>> rtl/mbfp_top.sv
// bridge fault-protection logic with APB register access
// assumes comparator and pin inputs are asynchronous; initDiag comes from core-clock logic

// level filter: hit rises after lvl holds for limit cycles, drops when lvl drops
module mbfp_filter (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // condition
  input  wire logic        clr,
  input  wire logic        lvl,
  input  wire logic [31:0] limit,
  // result
  output logic             hit
);
  logic [31:0] cnt_r;
  logic        hit_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      hit_r <= 1'b0;
    end else if (clr || !lvl) begin
      cnt_r <= '0;
      hit_r <= 1'b0;
    end else if (cnt_r >= limit - 32'h1) begin
      hit_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  assign hit = hit_r;
endmodule // mbfp_filter

module mbfp_top import mbfp_pkg::*; #(
  parameter int unsigned VCC_UV_CYC = VCC_UV_CYC_DEF,
  parameter int unsigned RETRY_CYC  = RETRY_CYC_DEF
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator flags
  input  wire logic        batUvCmp,
  input  wire logic        vccUvCmp,
  input  wire logic        porCmp,
  input  wire logic        otCmp,
  input  wire logic [7:0]  ocCmp,
  // controller pins
  input  wire logic [1:0]  driveEnable,
  input  wire logic [1:0]  driveEnableLow_n,
  input  wire logic [3:0]  pwmIn,
  input  wire logic        halfBridgeMode,
  input  wire logic        initDiag,
  // bridge and diagnostic outputs
  output logic [3:0]       outDrive,
  output logic [3:0]       pwmOut,
  output logic [1:0]       faultIndicator_n,
  output logic             logicReset
);
  logic [SYNC_W-1:0] syncMeta_r;
  logic [SYNC_W-1:0] syncOut_r;
  logic              batUvS;
  logic              vccUvS;
  logic              porS;
  logic              otS;
  logic [7:0]        ocS;
  logic [1:0]        enS;
  logic [1:0]        enbS;
  logic [3:0]        pwmS;
  logic              halfS;
  logic              batUvHit;
  logic              vccUvHit;
  logic              porHit;
  logic              otActive_r;
  logic [1:0]        enPrev_r;
  logic [1:0]        enbPrev_r;
  logic [1:0]        restart;
  logic [1:0]        diagClr;
  logic [1:0]        enActive;
  logic [7:0]        ocLvl;
  logic [7:0]        ocHit;
  logic [7:0]        ocSet;
  logic [3:0]        ocStateAll;
  logic [3:0]        halfOff;
  logic [1:0]        diagOc;
  logic [1:0]        fullOff;
  logic [1:0]        retryHit;
  logic [31:0]       cfg_r [2];
  logic [31:0]       flags_r;
  logic [31:0]       flags_nxt;
  logic [31:0]       readMux;
  logic              addrOk;
  logic              apbDo;
  logic              wrFlags;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [3:0]        outDrive_r;
  logic [3:0]        pwmOut_r;
  logic [1:0]        fault_r;
  logic              porOut_r;

  // two-stage synchroniser for every comparator and controller pin input except initDiag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta_r <= SYNC_IDLE;
      syncOut_r  <= SYNC_IDLE;
    end else begin
      syncMeta_r <= {batUvCmp, vccUvCmp, porCmp, otCmp, ocCmp, driveEnable,
                     driveEnableLow_n, pwmIn, halfBridgeMode};
      syncOut_r  <= syncMeta_r;
    end
  end

  assign {batUvS, vccUvS, porS, otS, ocS, enS, enbS, pwmS, halfS} = syncOut_r;

  mbfp_filter uPor (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (1'b0),
    .lvl     (porS),
    .limit   (POR_CYC),
    .hit     (porHit)
  );

  mbfp_filter uBatUv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (porHit),
    .lvl     (batUvS),
    .limit   (BAT_UV_CYC),
    .hit     (batUvHit)
  );

  mbfp_filter uVccUv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (porHit),
    .lvl     (vccUvS),
    .limit   (VCC_UV_CYC),
    .hit     (vccUvHit)
  );

  // overtemperature is frozen during battery undervoltage, masked in diagnosis
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      otActive_r <= 1'b0;
    end else if (porHit) begin
      otActive_r <= 1'b0;
    end else if (initDiag) begin
      otActive_r <= 1'b0;
    end else if (!batUvHit) begin
      otActive_r <= otS;
    end
  end

  // enable pin edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enPrev_r  <= '0;
      enbPrev_r <= '1;
    end else begin
      enPrev_r  <= enS;
      enbPrev_r <= enbS;
    end
  end

  assign restart  = (enPrev_r & ~enS) | (~enbPrev_r & enbS);
  assign diagClr  = (~enPrev_r & enS) | (enbPrev_r & ~enbS);
  assign enActive = enS & ~enbS;
  assign ocLvl    = initDiag ? '0 : ocS;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      mbfp_oc_state_t state_r;
      logic [3:0]     hits;
      logic [3:0]     first;
      logic [1:0]     half_r;
      logic           fault_indicator_n_r;
      logic           autoMode;
      logic [31:0]    blankLim;

      assign hits     = ocHit[ch*4 +: 4];
      assign first    = hits & (~hits + 4'h1);
      assign autoMode = cfg_r[ch][CFG_AUTO_BIT] && !halfS;
      assign blankLim = cfg_r[ch][CFG_BLANK_BIT] ? BLANK_OC_CYC : BLANK_SHORT_CYC;

      for (genvar d = 0; d < 4; d++) begin : gDet
        mbfp_filter uOc (
          .clk_sys (clk_sys),
          .rst_n   (rst_n),
          .clr     (porHit),
          .lvl     (ocLvl[ch*4+d]),
          .limit   (blankLim),
          .hit     (ocHit[ch*4+d])
        );
      end

      mbfp_filter uRetry (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clr     (porHit || restart[ch]),
        .lvl     (state_r == MBFP_OC_WAIT && enActive[ch]),
        .limit   (RETRY_CYC),
        .hit     (retryHit[ch])
      );

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          state_r <= MBFP_OC_RUN;
        end else if (porHit || restart[ch]) begin
          state_r <= MBFP_OC_RUN;
        end else begin
          case (state_r)
            MBFP_OC_RUN: begin
              if (|hits) begin
                state_r <= autoMode ? MBFP_OC_WAIT : MBFP_OC_LATCH;
              end
            end
            MBFP_OC_WAIT: begin
              if (retryHit[ch]) begin
                state_r <= MBFP_OC_RUN;
              end
            end
            MBFP_OC_LATCH: begin
              state_r <= MBFP_OC_LATCH;
            end
            default: begin
              state_r <= MBFP_OC_RUN;
            end
          endcase
        end
      end

      // half-bridge mode: only the output whose detector fired stays off
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          half_r <= '0;
        end else if (porHit || restart[ch]) begin
          half_r <= '0;
        end else if (state_r == MBFP_OC_RUN && halfS) begin
          half_r <= half_r | {|first[3:2], |first[1:0]};
        end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          fault_indicator_n_r <= 1'b0;
        end else if (porHit) begin
          fault_indicator_n_r <= 1'b0;
        end else if (state_r == MBFP_OC_RUN && |hits) begin
          fault_indicator_n_r <= 1'b1;
        end else if (restart[ch] || diagClr[ch]) begin
          fault_indicator_n_r <= 1'b0;
        end
      end

      assign ocSet[ch*4 +: 4]      = (state_r == MBFP_OC_RUN) ? first : 4'h0;
      assign ocStateAll[ch*2 +: 2] = state_r;
      assign halfOff[ch*2 +: 2]    = half_r;
      assign diagOc[ch]            = fault_indicator_n_r;
      assign fullOff[ch]           = (state_r != MBFP_OC_RUN) && !halfS;
    end
  endgenerate

  // apb slave: one wait state, answer on the second access cycle
  assign apbDo   = psel && penable && pready_r;
  assign addrOk  = (paddr == ADDR_CFG_A) || (paddr == ADDR_CFG_B) ||
                   (paddr == ADDR_FLAGS) || (paddr == ADDR_STATE);
  assign wrFlags = apbDo && pwrite && (paddr == ADDR_FLAGS);

  always_comb begin
    case (paddr)
      ADDR_CFG_A: readMux = cfg_r[0];
      ADDR_CFG_B: readMux = cfg_r[1];
      ADDR_FLAGS: readMux = flags_r;
      ADDR_STATE: readMux = {19'h0, halfOff, ocStateAll, diagOc, otActive_r,
                             vccUvHit, batUvHit};
      default:    readMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !addrOk;
      prdata_r  <= (psel && penable && !pready_r && !pwrite) ? readMux : 32'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r[0] <= CFG_RESET;
      cfg_r[1] <= CFG_RESET;
    end else if (porHit) begin
      cfg_r[0] <= CFG_RESET;
      cfg_r[1] <= CFG_RESET;
    end else if (apbDo && pwrite) begin
      if (paddr == ADDR_CFG_A) cfg_r[0] <= pwdata & CFG_MASK;
      if (paddr == ADDR_CFG_B) cfg_r[1] <= pwdata & CFG_MASK;
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_comb begin
    flags_nxt = wrFlags ? (flags_r & ~pwdata) : flags_r;
    flags_nxt[FLAG_VCCUV_BIT] = flags_nxt[FLAG_VCCUV_BIT] | vccUvHit;
    flags_nxt[FLAG_OC_LSB +: 8] = flags_nxt[FLAG_OC_LSB +: 8] | ocSet;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else if (porHit) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // bridge outputs; battery undervoltage gates drive only, logic keeps running
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outDrive_r <= '0;
      pwmOut_r   <= '0;
      fault_r    <= '1;
      porOut_r   <= 1'b0;
    end else if (porHit) begin
      outDrive_r <= '0;
      pwmOut_r   <= '0;
      fault_r    <= '1;
      porOut_r   <= 1'b1;
    end else begin
      for (int i = 0; i < 4; i++) begin
        outDrive_r[i] <= enActive[i/2] && !batUvHit && !vccUvHit && !otActive_r &&
                         !(|fullOff) && !halfOff[i];
      end
      pwmOut_r <= otActive_r ? 4'h0 : pwmS;
      fault_r  <= ~({2{otActive_r}} | diagOc);
      porOut_r <= 1'b0;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign outDrive         = outDrive_r;
  assign pwmOut           = pwmOut_r;
  assign faultIndicator_n = fault_r;
  assign logicReset       = porOut_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sOcFire0;
    ocStateAll[1:0] == MBFP_OC_RUN && |ocHit[3:0] && !porHit && !restart[0];
  endsequence

  a_batuv_hiz: assert property (batUvHit && !porHit |=> outDrive == 4'h0)
    else $error("drive active during battery undervoltage");
  a_vccuv_hiz: assert property (vccUvHit && !porHit |=> outDrive == 4'h0)
    else $error("drive active during logic undervoltage");
  a_vccuv_flag: assert property (vccUvHit && !porHit |=> flags_r[FLAG_VCCUV_BIT])
    else $error("logic undervoltage flag not set");
  a_ot_frozen: assert property (batUvHit && !initDiag && !porHit |=> $stable(otActive_r))
    else $error("overtemperature changed during battery undervoltage");
  a_ot_shutdown: assert property (otActive_r && !porHit |=>
                                  outDrive == 4'h0 && faultIndicator_n == 2'b00)
    else $error("overtemperature did not shut down");
  a_ot_diagmask: assert property (initDiag && !porHit |=> !otActive_r)
    else $error("overtemperature seen in diagnosis");
  a_pwm_blocked: assert property (otActive_r && !porHit |=> pwmOut == 4'h0)
    else $error("pwm passed during overtemperature");
  a_oc_alloff: assert property (sOcFire0 and !halfS |=> ##1 outDrive == 4'h0
                                 && !faultIndicator_n[0])
    else $error("overcurrent did not cut all drivers");
  a_oc_blanking: assert property (!ocLvl[0] |=> !ocHit[0])
    else $error("overcurrent confirmed without blanking");
  a_oc_first: assert property (ocStateAll[1:0] != MBFP_OC_RUN && !wrFlags && !porHit
                               |=> $stable(flags_r[FLAG_OC_LSB +: 4]))
    else $error("second detector flag accepted");
  a_oc_restart: assert property (restart[0] && !porHit |=> ocStateAll[1:0] == MBFP_OC_RUN)
    else $error("restart did not clear off state");
endmodule // mbfp_top

// >>> rtl/mbfp_pkg.sv
// constants, register map and state type for the bridge fault-protection block
// assumes a single 250 MHz core clock; comparator flags arrive already analog-filtered
// Behaviour
// - battery undervoltage held 10.0 us turns both bridge pairs to high impedance
// - logic keeps running through battery undervoltage unless power-on reset strikes
// - overtemperature signal freezes while battery undervoltage is present
// - logic-supply undervoltage held 2.5 ms turns both bridge pairs off
// - logic-supply undervoltage sets a sticky flag readable by software
// - logic supply below reset level for 13.0 us resets all block logic except the input synchronisers, enable edge registers and apb handshake
// - overtemperature turns both pairs off and drives fault indicator low
// - overtemperature clearing resumes drive and releases the fault indicator
// - overtemperature is treated as absent during initial diagnosis
// - direct pulse-width inputs are ignored while overtemperature is active
// - confirmed overcurrent turns every driver off and drives fault indicator low
// - config bit 11 per channel selects latch-off (0) or automatic recovery (1)
// - half-bridge mode ignores recovery and latches only the faulty output off
// - first of four detectors per channel wins; others ignored until cancelled
// - overcurrent confirmed only after comparator held for the blanking time: 0.5 us, or 1 us if long
// - automatic recovery retries drive every 300 ms until the controller steps in
// - a retry without overcurrent returns both pairs to normal drive
// - enable fall or low-enable rise clears the off state and restarts
// - long overcurrent blanking when selected overrides the short blanking time
// - overcurrent detection held undetected during initial or restarted diagnosis
// - in latch mode enable rise or low-enable fall releases the fault indicator
package mbfp_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BAT_UV_NS      = 10000;
  localparam int unsigned VCC_UV_US      = 2500;
  localparam int unsigned POR_NS         = 13000;
  localparam int unsigned BLANK_OC_NS    = 1000;
  localparam int unsigned BLANK_SHORT_NS = 500;
  localparam int unsigned RETRY_MS       = 300;
  localparam int unsigned BAT_UV_CYC     = (BAT_UV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned VCC_UV_CYC_DEF = VCC_UV_US * CLK_MHZ;
  localparam int unsigned POR_CYC        = (POR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLANK_OC_CYC   = (BLANK_OC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLANK_SHORT_CYC = (BLANK_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RETRY_CYC_DEF  = RETRY_MS * CLK_MHZ * 1000;
  // register byte offsets
  localparam logic [7:0] ADDR_CFG_A = 8'h00;
  localparam logic [7:0] ADDR_CFG_B = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;
  localparam int unsigned CFG_AUTO_BIT  = 11;
  localparam int unsigned CFG_BLANK_BIT = 12;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK      = 32'h0000_1800;
  localparam int unsigned FLAG_VCCUV_BIT = 0;
  localparam int unsigned FLAG_OC_LSB    = 8;
  localparam int unsigned SYNC_W         = 21;
  // synchroniser reset value: every pin at its idle level, low enables high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 21'h00_0060;
  typedef enum logic [1:0] {
    MBFP_OC_RUN   = 2'b00,
    MBFP_OC_WAIT  = 2'b01,
    MBFP_OC_LATCH = 2'b11
  } mbfp_oc_state_t;
endpackage

// >>> verification/mbfp_mcu_model.sv
// partner model: the controlling microcontroller's enable pins
// assumes the bench calls its tasks hierarchically; pins change just after a rising edge
module mbfp_mcu_model (
  // clock
  input  wire logic       clk_sys,
  // enable pins
  output logic [1:0]      driveEnable,
  output logic [1:0]      driveEnableLow_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    driveEnable      = 2'b00;
    driveEnableLow_n = 2'b11;
  end

  task automatic enableAll;
    @(posedge clk_sys);
    driveEnable      <= 2'b11;
    driveEnableLow_n <= 2'b00;
  endtask

  // stop the channel, then one restart pulse: enable falls, later rises again
  task automatic restart(input int ch);
    @(posedge clk_sys);
    driveEnable[ch] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    driveEnable[ch] <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // mbfp_mcu_model

// >>> verification/test_motor_bridge_fault_protection.sv
// self-checking bench for the bridge fault-protection block
// assumes short retry and logic-undervoltage counts via parameters
module test_motor_bridge_fault_protection;
  import mbfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned VCC_N = 20;
  localparam int unsigned RETRY_N = 50;

  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, ocCmp;
  logic [31:0] pwdata, prdata, rd;
  logic        batUvCmp, vccUvCmp, porCmp, otCmp, halfBridgeMode, initDiag, logicReset, err;
  logic [1:0]  driveEnable, driveEnableLow_n, faultIndicator_n;
  logic [3:0]  pwmIn, outDrive, pwmOut;
  int          errCount, nCompared;

  mbfp_top #(.VCC_UV_CYC(VCC_N), .RETRY_CYC(RETRY_N)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .batUvCmp(batUvCmp), .vccUvCmp(vccUvCmp), .porCmp(porCmp), .otCmp(otCmp),
    .ocCmp(ocCmp), .driveEnable(driveEnable), .driveEnableLow_n(driveEnableLow_n),
    .pwmIn(pwmIn), .halfBridgeMode(halfBridgeMode), .initDiag(initDiag),
    .outDrive(outDrive), .pwmOut(pwmOut), .faultIndicator_n(faultIndicator_n),
    .logicReset(logicReset));

  mbfp_mcu_model i_mcu (
    .clk_sys(clk_sys), .driveEnable(driveEnable), .driveEnableLow_n(driveEnableLow_n));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one apb transfer; the watchdog bounds the wait for pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic clrFlags;
    apb(ADDR_FLAGS, 1'b1, 32'hffff_ffff);
  endtask

  task automatic testDone;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    tick(60000);
    errCount++;
    testDone;
  end

  initial begin
    errCount = 0; nCompared = 0;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; batUvCmp = 1'b0; vccUvCmp = 1'b0; porCmp = 1'b0; otCmp = 1'b0;
    ocCmp = 8'h00; pwmIn = 4'ha; halfBridgeMode = 1'b0; initDiag = 1'b0;
    tick(5);
    rst_n <= 1'b1;
    chk("rstDrive", {28'h0, outDrive}, 32'h0);
    chk("rstFault", {30'h0, faultIndicator_n}, 32'h3);
    i_mcu.enableAll();
    tick(10);
    chk("runDrive", {28'h0, outDrive}, 32'hf);
    chk("runPwm", {28'h0, pwmOut}, 32'ha);
    // config masking and unmapped access
    apb(ADDR_CFG_A, 1'b1, 32'hffff_ffff);
    apb(ADDR_CFG_A, 1'b0, 32'h0);
    chk("cfgMask", rd, 32'h0000_1800);
    apb(8'h10, 1'b0, 32'h0);
    chk("unmappedErr", {31'h0, err}, 32'h1);
    // overtemperature off, then resume
    otCmp <= 1'b1;
    tick(10);
    chk("otDrive", {28'h0, outDrive}, 32'h0);
    chk("otFault", {30'h0, faultIndicator_n}, 32'h0);
    chk("otPwm", {28'h0, pwmOut}, 32'h0);
    otCmp <= 1'b0;
    tick(10);
    chk("otEndDrive", {28'h0, outDrive}, 32'hf);
    chk("otEndFault", {30'h0, faultIndicator_n}, 32'h3);
    initDiag <= 1'b1;
    otCmp <= 1'b1;
    tick(10);
    chk("diagOt", {28'h0, outDrive}, 32'hf);
    ocCmp <= 8'h01;
    tick(300);
    chk("diagOc", {28'h0, outDrive}, 32'hf);
    otCmp <= 1'b0;
    ocCmp <= 8'h00;
    tick(5);
    initDiag <= 1'b0;
    // latch mode, long blanking: short glitch rejected, first detector wins
    apb(ADDR_CFG_A, 1'b1, 32'h0000_1000);
    ocCmp <= 8'h01;
    tick(200);
    ocCmp <= 8'h00;
    tick(10);
    chk("ocGlitch", {28'h0, outDrive}, 32'hf);
    ocCmp <= 8'h01;
    tick(240);
    ocCmp <= 8'h03;
    tick(300);
    chk("ocLatchDrive", {28'h0, outDrive}, 32'h0);
    chk("ocLatchFault", {30'h0, faultIndicator_n}, 32'h2);
    ocCmp <= 8'h00;
    apb(ADDR_FLAGS, 1'b0, 32'h0);
    chk("ocFirst", rd, 32'h0000_0100);
    tick(300);
    chk("ocHeld", {28'h0, outDrive}, 32'h0);
    i_mcu.restart(0);
    chk("restartDrive", {28'h0, outDrive}, 32'hf);
    chk("restartFault", {30'h0, faultIndicator_n}, 32'h3);
    clrFlags();
    // short blanking trips where long would not
    apb(ADDR_CFG_A, 1'b1, 32'h0);
    ocCmp <= 8'h04;
    tick(200);
    chk("shortBlank", {28'h0, outDrive}, 32'h0);
    ocCmp <= 8'h00;
    i_mcu.restart(0);
    clrFlags();
    // automatic recovery
    apb(ADDR_CFG_A, 1'b1, 32'h0000_1800);
    ocCmp <= 8'h08;
    tick(280);
    apb(ADDR_STATE, 1'b0, 32'h0);
    chk("retryWait", {30'h0, rd[6:5]}, 32'h1);
    ocCmp <= 8'h00;
    tick(RETRY_N + 30);
    chk("retryDrive", {28'h0, outDrive}, 32'hf);
    chk("retryFault", {30'h0, faultIndicator_n}, 32'h2);
    i_mcu.restart(0);
    clrFlags();
    // half bridge: only the faulty output latched, recovery ignored
    apb(ADDR_CFG_B, 1'b1, 32'h0000_1800);
    halfBridgeMode <= 1'b1;
    tick(5);
    ocCmp <= 8'h20;
    tick(280);
    ocCmp <= 8'h00;
    tick(RETRY_N + 50);
    chk("halfDrive", {28'h0, outDrive}, 32'hb);
    chk("halfFault", {30'h0, faultIndicator_n}, 32'h1);
    i_mcu.restart(1);
    halfBridgeMode <= 1'b0;
    clrFlags();
    // battery undervoltage: filter, off, logic alive, overtemperature frozen
    batUvCmp <= 1'b1;
    tick(2400);
    chk("batEarly", {28'h0, outDrive}, 32'hf);
    tick(200);
    chk("batOff", {28'h0, outDrive}, 32'h0);
    otCmp <= 1'b1;
    tick(10);
    chk("batFreeze", {30'h0, faultIndicator_n}, 32'h3);
    apb(ADDR_STATE, 1'b0, 32'h0);
    chk("batState", {29'h0, rd[2:0]}, 32'h1);
    batUvCmp <= 1'b0;
    tick(10);
    chk("batOtSeen", {30'h0, faultIndicator_n}, 32'h0);
    otCmp <= 1'b0;
    // logic-supply undervoltage
    vccUvCmp <= 1'b1;
    tick(VCC_N + 10);
    chk("vccOff", {28'h0, outDrive}, 32'h0);
    vccUvCmp <= 1'b0;
    tick(10);
    apb(ADDR_FLAGS, 1'b0, 32'h0);
    chk("vccFlag", rd, 32'h1);
    clrFlags();
    apb(ADDR_FLAGS, 1'b0, 32'h0);
    chk("vccFlagClr", rd, 32'h0);
    // power-on reset clears configuration
    porCmp <= 1'b1;
    tick(3300);
    chk("porActive", {31'h0, logicReset}, 32'h1);
    porCmp <= 1'b0;
    tick(5);
    apb(ADDR_CFG_A, 1'b0, 32'h0);
    chk("porCfg", rd, 32'h0);
    testDone;
  end
endmodule // test_motor_bridge_fault_protection
